// *** rcd_error_diag_regs.sv ***
`timescale 1ns/1ps
`include "rcd_regs.svh"

module rcd_error_diag_regs
    import rcd_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic xmem_access_valid,
    input wire logic [3:0] xmem_access_page,
    input wire logic [3:0] xmem_page_mapping,
    input wire logic [7:0] core_diag_in,
    input wire logic [511:0] diag_src,
    output rcd_diag_t radio_core_diag_port,
    output rcd_diag_t diag_lane4_out,
    output rcd_diag_t diag_lane5_out,
    output rcd_diag_t diag_lane6_out,
    output rcd_diag_t diag_lane7_out,
    output logic [6:0] xmem_base_field,
    output logic radio_core_error_irq
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic rcd_reg_e reg_sel(input logic [31:0] addr);
        case (addr)
            `RCD_ADDR_CTRL: reg_sel = RCD_SEL_CTRL;
            `RCD_ADDR_BASE: reg_sel = RCD_SEL_BASE;
            `RCD_ADDR_LANES: reg_sel = RCD_SEL_LANES;
            `RCD_ADDR_FORCE: reg_sel = RCD_SEL_FORCE;
            default: reg_sel = RCD_SEL_NONE;
        endcase
    endfunction : reg_sel

    // Byte-lane merge; bits outside rw_mask are never stored, so they read zero
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] rw_mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & rw_mask;
        merge = (old & ~m) | (data & m);
    endfunction : merge

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic wr_en;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [31:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    rcd_reg_e wr_sel;
    rcd_reg_e rd_sel;

    rcd_axil_slave u_slave (
        .clock(clock),
        .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ok(wr_ok),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_ok(rd_ok)
    );

    assign wr_sel = reg_sel(wr_addr);
    assign rd_sel = reg_sel(rd_addr);
    assign wr_ok = (wr_sel != RCD_SEL_NONE);
    assign rd_ok = (rd_sel != RCD_SEL_NONE);

    // ----------------------------------------
    // Error status, mask and interrupt
    // ----------------------------------------
    logic status_q;
    logic mask_q;
    logic ovr_q;
    logic err_evt;
    logic ack_clr;
    logic ctrl_wr;

    assign ctrl_wr = wr_en && (wr_sel == RCD_SEL_CTRL) && wr_strb[0];
    // Mapping holds the number of mapped pages; anything at or above it is unmapped
    assign err_evt = xmem_access_valid && (xmem_access_page >= xmem_page_mapping);
    assign ack_clr = ctrl_wr && wr_data[`RCD_CTRL_ACK_BIT];

    // A new error in the acknowledge cycle wins, so no error is silently dropped
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_q <= 1'b0;
        end else if (err_evt) begin
            status_q <= 1'b1;
        end else if (ack_clr) begin
            status_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mask_q <= `RCD_MASK_RESET;
            ovr_q <= `RCD_OVR_RESET;
        end else if (ctrl_wr) begin
            mask_q <= wr_data[`RCD_CTRL_MASK_BIT];
            ovr_q <= wr_data[`RCD_CTRL_OVR_BIT];
        end
    end

    assign radio_core_error_irq = status_q && mask_q;

    // ----------------------------------------
    // Exchange memory base and lane selects
    // ----------------------------------------
    logic [31:0] base_q;
    logic [31:0] lanes_q;
    rcd_diag_t force_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            base_q <= `RCD_BASE_RESET;
        end else if (wr_en && wr_sel == RCD_SEL_BASE) begin
            base_q <= merge(base_q, wr_data, wr_strb, `RCD_BASE_RW_MASK);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lanes_q <= `RCD_LANES_RESET;
        end else if (wr_en && wr_sel == RCD_SEL_LANES) begin
            lanes_q <= merge(lanes_q, wr_data, wr_strb, `RCD_LANES_RW_MASK);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            force_q <= `RCD_FORCE_RESET;
        end else if (wr_en && wr_sel == RCD_SEL_FORCE && wr_strb[0]) begin
            force_q <= wr_data[7:0];
        end
    end

    assign xmem_base_field = base_q[`RCD_BASE_MSB:`RCD_BASE_LSB];

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    always_comb begin
        rd_data = 32'h0;
        case (rd_sel)
            RCD_SEL_CTRL: begin
                // Acknowledge is write-only and always reads zero
                rd_data[`RCD_CTRL_STAT_BIT] = status_q;
                rd_data[`RCD_CTRL_ACK_BIT] = 1'b0;
                rd_data[`RCD_CTRL_MASK_BIT] = mask_q;
                rd_data[`RCD_CTRL_OVR_BIT] = ovr_q;
            end
            RCD_SEL_BASE: rd_data = base_q;
            RCD_SEL_LANES: rd_data = lanes_q;
            RCD_SEL_FORCE: rd_data = {24'h0, force_q};
            default: rd_data = 32'h0;
        endcase
    end

    // ----------------------------------------
    // Diagnostic port and lanes
    // ----------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            radio_core_diag_port <= `RCD_FORCE_RESET;
        end else if (ovr_q) begin
            radio_core_diag_port <= force_q;
        end else begin
            radio_core_diag_port <= core_diag_in;
        end
    end

    rcd_diag_t lane_word [`RCD_LANE_COUNT];

    genvar k;
    generate
        for (k = 0; k < `RCD_LANE_COUNT; k++) begin : g_lane
            rcd_diag_lane u_lane (
                .clock(clock),
                .resetn(resetn),
                .enable(lanes_q[k * `RCD_LANE_STRIDE + `RCD_LANE_EN_BIT]),
                .select(lanes_q[k * `RCD_LANE_STRIDE +: `RCD_LANE_SEL_W]),
                .src(diag_src),
                .lane_q(lane_word[k])
            );
        end
    endgenerate

    assign diag_lane4_out = lane_word[0];
    assign diag_lane5_out = lane_word[1];
    assign diag_lane6_out = lane_word[2];
    assign diag_lane7_out = lane_word[3];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_override_pass: assert property (
        @(posedge clock) disable iff (!resetn)
        !ovr_q |=> (radio_core_diag_port == $past(core_diag_in)))
        else $error("diag port not passed through");

    a_override_force: assert property (
        @(posedge clock) disable iff (!resetn)
        ovr_q |=> (radio_core_diag_port == $past(force_q)))
        else $error("diag port not overruled");

    a_irq_gating: assert property (
        @(posedge clock) disable iff (!resetn)
        $rose(radio_core_error_irq) |-> ($past(err_evt) || $past(ctrl_wr)))
        else $error("error irq rose without an error or a mask write");

    a_irq_masked_err: assert property (
        @(posedge clock) disable iff (!resetn)
        (err_evt && mask_q && !ctrl_wr) |=> radio_core_error_irq)
        else $error("unmasked error did not raise irq");

    a_ack_clears: assert property (
        @(posedge clock) disable iff (!resetn)
        (ack_clr && !err_evt) |=> !status_q)
        else $error("acknowledge did not clear status");

    a_ack_zero_noop: assert property (
        @(posedge clock) disable iff (!resetn)
        (status_q && ctrl_wr && !wr_data[`RCD_CTRL_ACK_BIT]) |=> status_q)
        else $error("writing zero to acknowledge changed status");

    a_ack_reads_zero: assert property (
        @(posedge clock) disable iff (!resetn)
        (rd_en && rd_sel == RCD_SEL_CTRL) |=> (s_axi_rvalid && !s_axi_rdata[1]))
        else $error("acknowledge bit read back as one");

    a_status_sticky: assert property (
        @(posedge clock) disable iff (!resetn)
        (status_q && !ack_clr) |=> status_q)
        else $error("status cleared without acknowledge");

    a_error_sets: assert property (
        @(posedge clock) disable iff (!resetn)
        err_evt |=> status_q [*1] ##0 (rd_data[0] || rd_sel != RCD_SEL_CTRL))
        else $error("access error did not set status");

    a_base_reserved: assert property (
        @(posedge clock) disable iff (!resetn)
        (base_q[31:17] == 15'h0) && (base_q[9:0] == 10'h0))
        else $error("base reserved bits not zero");

    a_base_write: assert property (
        @(posedge clock) disable iff (!resetn)
        (wr_en && wr_sel == RCD_SEL_BASE && wr_strb == 4'hf)
            |=> (xmem_base_field == $past(wr_data[16:10])))
        else $error("base field not written");

    a_lane_reserved: assert property (
        @(posedge clock) disable iff (!resetn)
        (lanes_q[30] || lanes_q[22] || lanes_q[14] || lanes_q[6]) == 1'b0)
        else $error("lane reserved bits not zero");

    a_set_wins: assert property (
        @(posedge clock) disable iff (!resetn)
        (err_evt && ack_clr) |=> status_q)
        else $error("acknowledge dropped a same-cycle error");

    a_clear_by_ack: assert property (
        @(posedge clock) disable iff (!resetn)
        $fell(status_q) |-> $past(ack_clr))
        else $error("status cleared without an acknowledge write");

    a_mask_write: assert property (
        @(posedge clock) disable iff (!resetn)
        ctrl_wr |=> (mask_q == $past(wr_data[`RCD_CTRL_MASK_BIT])))
        else $error("mask bit not written");

    a_base_hold: assert property (
        @(posedge clock) disable iff (!resetn)
        !(wr_en && wr_sel == RCD_SEL_BASE) |=> $stable(base_q))
        else $error("base register changed without a write");

    a_lane4_map: assert property (
        @(posedge clock) disable iff (!resetn)
        lanes_q[7] |=> (diag_lane4_out == $past(diag_src[{lanes_q[5:0], 3'h0} +: 8])))
        else $error("lane 4 output does not follow its select field");

    a_lane7_off: assert property (
        @(posedge clock) disable iff (!resetn)
        !lanes_q[31] |=> (diag_lane7_out == 8'h00))
        else $error("disabled lane 7 output not zero");

endmodule : rcd_error_diag_regs

// *** rcd_regs.svh ***
`ifndef RCD_REGS_SVH
`define RCD_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RCD_ADDR_CTRL 32'h4000_0204
`define RCD_ADDR_BASE 32'h4000_0208
`define RCD_ADDR_LANES 32'h4000_020c
`define RCD_ADDR_FORCE 32'h4000_0214

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define RCD_CTRL_STAT_BIT 0
`define RCD_CTRL_ACK_BIT 1
`define RCD_CTRL_MASK_BIT 2
`define RCD_CTRL_OVR_BIT 3
`define RCD_MASK_RESET 1'h1
`define RCD_OVR_RESET 1'h0
`define RCD_BASE_LSB 10
`define RCD_BASE_MSB 16
`define RCD_BASE_RW_MASK 32'h0001_fc00
`define RCD_BASE_RESET 32'h0000_0000
`define RCD_LANES_RW_MASK 32'hbfbf_bfbf
`define RCD_LANES_RESET 32'h0000_0000
`define RCD_LANE_STRIDE 8
`define RCD_LANE_EN_BIT 7
`define RCD_LANE_SEL_W 6
`define RCD_LANE_COUNT 4
`define RCD_FORCE_RESET 8'h00
`define RCD_DIAG_W 8
`define RCD_SRC_W 512
`define RCD_PAGE_W 4
`define RCD_RESP_OKAY 2'h0
`define RCD_RESP_SLVERR 2'h2

`endif

// *** rcd_pkg.sv ***
package rcd_pkg;

    typedef enum logic [4:0] {
        RCD_SEL_NONE = 5'h01,
        RCD_SEL_CTRL = 5'h02,
        RCD_SEL_BASE = 5'h04,
        RCD_SEL_LANES = 5'h08,
        RCD_SEL_FORCE = 5'h10
    } rcd_reg_e;

    typedef logic [7:0] rcd_diag_t;

endpackage : rcd_pkg

// *** rcd_axil_slave.sv ***
`timescale 1ns/1ps
`include "rcd_regs.svh"

module rcd_axil_slave
    import rcd_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ok,
    output logic rd_en,
    output logic [31:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_ok
);

    logic aw_have_q;
    logic w_have_q;

    // Address and data may arrive in either order; each is parked until both are here
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_en = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_addr <= 32'h0;
            wr_data <= 32'h0;
            wr_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end else if (wr_en) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end else if (wr_en) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RCD_RESP_OKAY;
        end else if (wr_en) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RCD_RESP_OKAY : `RCD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RCD_RESP_OKAY;
        end else if (rd_en) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? rd_data : 32'h0;
            s_axi_rresp <= rd_ok ? `RCD_RESP_OKAY : `RCD_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : rcd_axil_slave

// *** rcd_diag_lane.sv ***
`timescale 1ns/1ps
`include "rcd_regs.svh"

module rcd_diag_lane
    import rcd_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic enable,
    input wire logic [5:0] select,
    input wire logic [511:0] src,
    output rcd_diag_t lane_q
);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lane_q <= `RCD_FORCE_RESET;
        end else if (enable) begin
            lane_q <= src[{select, 3'h0} +: `RCD_DIAG_W];
        end else begin
            lane_q <= `RCD_FORCE_RESET;
        end
    end

    a_lane_disabled_zero: assert property (
        @(posedge clock) disable iff (!resetn)
        !enable |=> (lane_q == 8'h00))
        else $error("disabled lane is not zero");

    a_lane_select_word: assert property (
        @(posedge clock) disable iff (!resetn)
        enable |=> (lane_q == $past(src[{select, 3'h0} +: 8])))
        else $error("lane does not carry the selected word");

endmodule : rcd_diag_lane

// *** rcd_error_diag_regs_test.sv ***
`timescale 1ns/1ps
`include "rcd_regs.svh"

module rcd_error_diag_regs_test
    import rcd_pkg::*;
;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [31:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic xmem_access_valid = 1'b0;
    logic [3:0] xmem_access_page = '0;
    logic [3:0] xmem_page_mapping = 4'h4;
    logic [7:0] core_diag_in = '0;
    logic [511:0] diag_src = '0;
    rcd_diag_t radio_core_diag_port;
    rcd_diag_t diag_lane4_out;
    rcd_diag_t diag_lane5_out;
    rcd_diag_t diag_lane6_out;
    rcd_diag_t diag_lane7_out;
    logic [6:0] xmem_base_field;
    logic radio_core_error_irq;
    int error_cnt = 0;
    int checks_done = 0;

    always #25 clock = ~clock;

    rcd_error_diag_regs u_dut (
        .clock(clock), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .xmem_access_valid(xmem_access_valid),
        .xmem_access_page(xmem_access_page), .xmem_page_mapping(xmem_page_mapping),
        .core_diag_in(core_diag_in), .diag_src(diag_src),
        .radio_core_diag_port(radio_core_diag_port),
        .diag_lane4_out(diag_lane4_out), .diag_lane5_out(diag_lane5_out),
        .diag_lane6_out(diag_lane6_out), .diag_lane7_out(diag_lane7_out),
        .xmem_base_field(xmem_base_field), .radio_core_error_irq(radio_core_error_irq)
    );

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic hang(input string what);
        error_cnt++;
        $display("[FAIL] %0t: no answer on %s", $time, what);
        print_verdict();
    endtask : hang

    // ----------------------------------------
    // Bus master
    // ----------------------------------------
    // Address and data are offered together; each is released once taken.
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        int n;
        aw_ok = 0;
        w_ok = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100 && !(aw_ok && w_ok); n++) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (!(aw_ok && w_ok)) hang("write address or data");
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 100) hang("write response");
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 100) hang("read data");
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic wr_ok(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, r);
        check(r, `RCD_RESP_OKAY, "write response");
    endtask : wr_ok

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(r, `RCD_RESP_OKAY, "read response");
        check(d, exp, "read data");
    endtask : rd_chk

    // One controller access to exchange memory
    task automatic access(input logic [3:0] page);
        @(posedge clock);
        xmem_access_valid <= 1'b1;
        xmem_access_page <= page;
        @(posedge clock);
        xmem_access_valid <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : access

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_reset();
        rd_chk(`RCD_ADDR_CTRL, 32'h0000_0004);
        rd_chk(`RCD_ADDR_BASE, 32'h0000_0000);
        rd_chk(`RCD_ADDR_LANES, 32'h0000_0000);
        check(radio_core_error_irq, 1'b0, "irq after reset");
    endtask : test_reset

    task automatic test_error();
        access(4'h3);
        rd_chk(`RCD_ADDR_CTRL, 32'h0000_0004);
        access(4'h4);
        check(radio_core_error_irq, 1'b1, "irq with mask set");
        rd_chk(`RCD_ADDR_CTRL, 32'h0000_0005);
        // Mask off, ack zero, attempt to clear status directly
        wr_ok(`RCD_ADDR_CTRL, 32'h0000_0001);
        rd_chk(`RCD_ADDR_CTRL, 32'h0000_0001);
        check(radio_core_error_irq, 1'b0, "irq masked");
        wr_ok(`RCD_ADDR_CTRL, 32'h0000_0004);
        check(radio_core_error_irq, 1'b1, "irq unmasked");
        wr_ok(`RCD_ADDR_CTRL, 32'h0000_0006);
        rd_chk(`RCD_ADDR_CTRL, 32'h0000_0004);
        check(radio_core_error_irq, 1'b0, "irq after ack");
        // Wider mapping: page 7 is now mapped, page 9 is not
        xmem_page_mapping <= 4'h8;
        access(4'h7);
        rd_chk(`RCD_ADDR_CTRL, 32'h0000_0004);
        access(4'h9);
        rd_chk(`RCD_ADDR_CTRL, 32'h0000_0005);
        wr_ok(`RCD_ADDR_CTRL, 32'h0000_0006);
        check(radio_core_error_irq, 1'b0, "irq after second ack");
    endtask : test_error

    task automatic test_base();
        wr_ok(`RCD_ADDR_BASE, 32'hffff_ffff);
        rd_chk(`RCD_ADDR_BASE, 32'h0001_fc00);
        check(xmem_base_field, 7'h7f, "base field");
        wr_ok(`RCD_ADDR_BASE, 32'h0000_a400);
        check(xmem_base_field, 7'h29, "base field");
    endtask : test_base

    task automatic test_lanes();
        wr_ok(`RCD_ADDR_LANES, 32'hffff_ffff);
        rd_chk(`RCD_ADDR_LANES, 32'hbfbf_bfbf);
        // Lane 4 keeps a select value while disabled
        wr_ok(`RCD_ADDR_LANES, 32'hbf80_952a);
        repeat (3) @(posedge clock);
        check(diag_lane7_out, 8'h3f ^ 8'h5a, "lane 7");
        check(diag_lane6_out, 8'h00 ^ 8'h5a, "lane 6");
        check(diag_lane5_out, 8'h15 ^ 8'h5a, "lane 5");
        check(diag_lane4_out, 8'h00, "lane 4 disabled");
        wr_ok(`RCD_ADDR_LANES, 32'h3f00_15aa);
        repeat (3) @(posedge clock);
        check(diag_lane7_out, 8'h00, "lane 7 disabled");
        check(diag_lane6_out, 8'h00, "lane 6 disabled");
        check(diag_lane5_out, 8'h00, "lane 5 disabled");
        check(diag_lane4_out, 8'h2a ^ 8'h5a, "lane 4");
    endtask : test_lanes

    task automatic test_override();
        @(posedge clock);
        core_diag_in <= 8'h3c;
        repeat (3) @(posedge clock);
        check(radio_core_diag_port, 8'h3c, "port pass-through");
        wr_ok(`RCD_ADDR_FORCE, 32'h0000_00a5);
        wr_ok(`RCD_ADDR_CTRL, 32'h0000_000c);
        repeat (2) @(posedge clock);
        check(radio_core_diag_port, 8'ha5, "port overruled");
        rd_chk(`RCD_ADDR_CTRL, 32'h0000_000c);
        wr_ok(`RCD_ADDR_CTRL, 32'h0000_0004);
        repeat (2) @(posedge clock);
        check(radio_core_diag_port, 8'h3c, "port released");
    endtask : test_override

    task automatic test_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        axi_write(32'h4000_0200, 32'hffff_ffff, r);
        check(r, `RCD_RESP_SLVERR, "unmapped write response");
        axi_read(32'h4000_0300, d, r);
        check(r, `RCD_RESP_SLVERR, "unmapped read response");
        check(d, 32'h0, "unmapped read data");
    endtask : test_unmapped

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 64; i++) begin
            diag_src[i*8 +: 8] <= 8'(i) ^ 8'h5a;
        end
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        test_reset();
        test_error();
        test_base();
        test_lanes();
        test_override();
        test_unmapped();
        print_verdict();
    end

endmodule : rcd_error_diag_regs_test
